// [logic/hss_home_search.sv]
// Automatic home search sequencer with AHB-Lite register access
`timescale 1ns/10ps

// Behaviour
// - Axis word: D10 level, D11 enable, D12 stop
// - Detection limit honoured even if disabled
// - Home sensor low ends step two
// - Step three runs low speed until index
// - Index active halts output instantly
// - Index falling edge fires clear pulse
// - Index active clears both position counters
// - Mode1 D11 step3 direction, D10 enable
// - Mode1 D9..D4 step two options
// - Mode1 D3..D0 step one options
// - Mode1 D15 offset, D14..D12 step three
// - Mode2 timer value, enable, pulse width
// - Mode2 polarity and end-of-search clears
// - Minus limit has selectable delay filter
// - Start inside limit: skip, escape, search
module hss_home_search #(
  parameter int unsigned FILTER_UNIT_CYC = hss_pkg::FILTER_UNIT_CYC,
  parameter int unsigned PULSE_UNIT_CYC  = hss_pkg::PULSE_UNIT_CYC,
  parameter int unsigned TIMER_UNIT_CYC  = hss_pkg::TIMER_UNIT_CYC
) (
  input  wire logic        REF_CLK,
  input  wire logic        ARST_N,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        HOME_SENSOR_INPUT_N,
  input  wire logic        ENCODER_INDEX_INPUT_N,
  input  wire logic        MINUS_LIMIT_INPUT,
  input  wire logic        PLUS_LIMIT_INPUT,
  input  wire logic        DRIVE_BUSY,
  output logic             DRIVE_START,
  output logic             DRIVE_FIXED,
  output logic             DRIVE_DIR_MINUS,
  output logic      [31:0] DRIVE_SPEED,
  output logic      [31:0] DRIVE_COUNT,
  output logic             DRIVE_STOP_DEC,
  output logic             DRIVE_STOP_NOW,
  output logic             DEVIATION_CLEAR_OUTPUT,
  output logic             LOGICAL_POSITION_COUNTER_CLR,
  output logic             REAL_POSITION_COUNTER_CLR,
  output logic             SEARCH_BUSY
);

  typedef struct packed {
    hss_pkg::hss_state_t state;
    logic [15:0] cmd;
    logic [15:0] axis_mode;
    logic [15:0] data_lo;
    logic [15:0] data_hi;
    logic [15:0] mode1;
    logic [15:0] mode2;
    logic [15:0] filt_mode;
    logic [31:0] speed_hi;
    logic [31:0] speed_lo;
    logic [31:0] offset;
    logic        cmd_pend;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] rdata;
    logic [2:0]  step;
    logic        escaping;
    logic        busy_seen;
    logic        err_limit;
    logic [31:0] timer;
    logic        idx_prev;
    logic        drv_start;
    logic        drv_fixed;
    logic        drv_dir_minus;
    logic [31:0] drv_speed;
    logic [31:0] drv_count;
    logic        drv_stop_dec;
    logic        drv_stop_now;
    logic        lp_clr;
    logic        rp_clr;
    logic        clr_fire;
  } hss_core_t;

  hss_core_t              q_reg;
  hss_core_t              q_next;
  logic [hss_pkg::IN_COUNT-1:0] raw_in;
  logic [hss_pkg::IN_COUNT-1:0] filt_in;
  logic                   home_act;
  logic                   idx_act;
  logic                   idx_fall;
  logic                   lim_m_act;
  logic                   lim_p_act;
  logic [4:1]             step_en;
  logic [4:1]             step_dir;
  logic [4:1]             step_lim;
  logic [4:1]             step_det;
  logic                   drive_lim;
  logic                   accept;
  logic [31:0]            data_word;
  logic [31:0]            timer_len;

  // ****************************************
  // Input filters
  // ****************************************
  assign raw_in = {PLUS_LIMIT_INPUT, MINUS_LIMIT_INPUT, ENCODER_INDEX_INPUT_N,
                   HOME_SENSOR_INPUT_N};

  generate
    for (genvar i = 0; i < hss_pkg::IN_COUNT; i++) begin : g_filter
      hss_input_filter #(
        .UNIT_CYC (FILTER_UNIT_CYC)
      ) u_filter (
        .clk      (REF_CLK),
        .arst_n   (ARST_N),
        .raw      (raw_in[i]),
        .enable   (q_reg.filt_mode[i]),
        .code     (q_reg.filt_mode[hss_pkg::FM_CODE_HI:hss_pkg::FM_CODE_LO]),
        .filtered (filt_in[i])
      );
    end
  endgenerate

  // ****************************************
  // Detection decode per step
  // ****************************************
  always_comb begin
    home_act  = ~filt_in[hss_pkg::IN_HOME];
    idx_act   = ~filt_in[hss_pkg::IN_INDEX];
    idx_fall  = q_reg.idx_prev & ~filt_in[hss_pkg::IN_INDEX];
    lim_m_act = filt_in[hss_pkg::IN_LIM_M] ~^ q_reg.axis_mode[hss_pkg::AX_LIMIT_HIGH];
    lim_p_act = filt_in[hss_pkg::IN_LIM_P] ~^ q_reg.axis_mode[hss_pkg::AX_LIMIT_HIGH];
    step_en   = {q_reg.mode1[hss_pkg::M1_S4_EN], q_reg.mode1[hss_pkg::M1_S3_EN],
                 q_reg.mode1[hss_pkg::M1_S2_EN], q_reg.mode1[hss_pkg::M1_S1_EN]};
    // Offset direction comes from the sign of the programmed count
    step_dir  = {q_reg.offset[31], q_reg.mode1[hss_pkg::M1_S3_DIR],
                 q_reg.mode1[hss_pkg::M1_S2_DIR], q_reg.mode1[hss_pkg::M1_S1_DIR]};
    step_lim  = {1'b0, 1'b0, q_reg.mode1[hss_pkg::M1_S2_SEL],
                 q_reg.mode1[hss_pkg::M1_S1_SEL_HI:hss_pkg::M1_S1_SEL_LO] == hss_pkg::SEL_LIMIT};
    step_det[1] = step_lim[1] ? (step_dir[1] ? lim_m_act : lim_p_act) :
                  (q_reg.mode1[hss_pkg::M1_S1_SEL_HI:hss_pkg::M1_S1_SEL_LO] == hss_pkg::SEL_INDEX)
                  ? idx_act : home_act;
    step_det[2] = step_lim[2] ? (step_dir[2] ? lim_m_act : lim_p_act) : home_act;
    step_det[3] = idx_act;
    step_det[4] = 1'b0;
    drive_lim   = q_reg.drv_dir_minus ? lim_m_act : lim_p_act;
  end

  assign accept    = HSEL & HTRANS[1] & HREADY;
  assign data_word = {q_reg.data_hi, q_reg.data_lo};
  assign timer_len = 32'(TIMER_UNIT_CYC *
                     hss_pkg::hss_units(q_reg.mode2[hss_pkg::M2_TIMER_HI:hss_pkg::M2_TIMER_LO]));

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    q_next              = q_reg;
    q_next.drv_start    = 1'b0;
    q_next.drv_stop_dec = 1'b0;
    q_next.drv_stop_now = 1'b0;
    q_next.lp_clr       = 1'b0;
    q_next.rp_clr       = 1'b0;
    q_next.clr_fire     = 1'b0;
    q_next.cmd_pend     = 1'b0;
    q_next.idx_prev     = filt_in[hss_pkg::IN_INDEX];

    // Bus data phase: a command word executes the cycle after it lands
    q_next.wr_pend = accept & HWRITE;
    if (accept) begin
      q_next.wr_addr = HADDR[7:0];
    end
    if (q_reg.wr_pend) begin
      case (q_reg.wr_addr)
        hss_pkg::ADDR_COMMAND: begin
          q_next.cmd      = HWDATA[15:0];
          q_next.cmd_pend = 1'b1;
        end
        hss_pkg::ADDR_AXIS:    q_next.axis_mode = HWDATA[15:0];
        hss_pkg::ADDR_DATA_LO: q_next.data_lo   = HWDATA[15:0];
        hss_pkg::ADDR_DATA_HI: q_next.data_hi   = HWDATA[15:0];
        default: ;
      endcase
    end
    if (accept && !HWRITE) begin
      case (HADDR[7:0])
        hss_pkg::ADDR_COMMAND: q_next.rdata = {16'h0000, q_reg.cmd};
        hss_pkg::ADDR_AXIS:    q_next.rdata = {16'h0000, q_reg.axis_mode};
        hss_pkg::ADDR_DATA_LO: q_next.rdata = {16'h0000, q_reg.data_lo};
        hss_pkg::ADDR_DATA_HI: q_next.rdata = {16'h0000, q_reg.data_hi};
        hss_pkg::ADDR_STATUS:  q_next.rdata = {22'h000000, filt_in, q_reg.state[5:1] != 5'h00,
                                               q_reg.err_limit, q_reg.step, SEARCH_BUSY};
        hss_pkg::ADDR_MODE1:   q_next.rdata = {16'h0000, q_reg.mode1};
        hss_pkg::ADDR_MODE2:   q_next.rdata = {16'h0000, q_reg.mode2};
        default:               q_next.rdata = 32'h0000_0000;
      endcase
    end

    // Command execution
    if (q_reg.cmd_pend) begin
      case (q_reg.cmd)
        hss_pkg::CMD_MODE1:      q_next.mode1     = q_reg.data_lo;
        hss_pkg::CMD_MODE2:      q_next.mode2     = q_reg.data_lo;
        hss_pkg::CMD_FILTER:     q_next.filt_mode = q_reg.data_lo;
        hss_pkg::CMD_SPEED_HIGH: q_next.speed_hi  = data_word;
        hss_pkg::CMD_SPEED_LOW:  q_next.speed_lo  = data_word;
        hss_pkg::CMD_OFFSET:     q_next.offset    = data_word;
        hss_pkg::CMD_START: begin
          // A start while a search runs is ignored
          if (q_reg.state == hss_pkg::S_IDLE) begin
            q_next.state     = hss_pkg::S_NEXT;
            q_next.step      = 3'h0;
            q_next.err_limit = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // Sequencer
    unique case (q_reg.state)
      hss_pkg::S_IDLE: ;
      hss_pkg::S_NEXT: begin
        q_next.step = q_reg.step + 3'h1;
        if (q_reg.step == 3'h4) begin
          q_next.state = hss_pkg::S_DONE;
        end else if (step_en[q_next.step] &&
                     !(q_next.step == 3'h1 && step_det[1])) begin
          q_next.escaping      = (q_next.step == 3'h2) && step_det[2];
          q_next.drv_dir_minus = step_dir[q_next.step] ^ q_next.escaping;
          q_next.drv_fixed     = q_next.step == 3'h4;
          q_next.drv_speed     = (q_next.step == 3'h1 || q_next.step == 3'h4)
                                 ? q_reg.speed_hi : q_reg.speed_lo;
          q_next.drv_count     = q_reg.offset[31] ? 32'h0000_0000 - q_reg.offset
                                 : q_reg.offset;
          q_next.drv_start     = 1'b1;
          q_next.busy_seen     = 1'b0;
          q_next.state         = hss_pkg::S_RUN;
        end
      end
      hss_pkg::S_RUN: begin
        q_next.busy_seen = q_reg.busy_seen | DRIVE_BUSY;
        if (q_reg.axis_mode[hss_pkg::AX_LIMIT_EN] && drive_lim && !step_lim[q_reg.step] &&
            !q_reg.drv_start) begin
          // Ordinary limit stop aborts the whole search
          q_next.drv_stop_dec = q_reg.axis_mode[hss_pkg::AX_LIMIT_DEC];
          q_next.drv_stop_now = ~q_reg.axis_mode[hss_pkg::AX_LIMIT_DEC];
          q_next.err_limit    = 1'b1;
          q_next.state        = hss_pkg::S_WAIT;
        end else if (q_reg.escaping) begin
          if (!step_det[2]) begin
            q_next.drv_stop_dec = 1'b1;
            q_next.state        = hss_pkg::S_WAIT;
          end
        end else if (q_reg.step == 3'h4) begin
          if (q_reg.busy_seen && !DRIVE_BUSY) begin
            q_next.state = hss_pkg::S_WAIT;
          end
        end else if (step_det[q_reg.step]) begin
          q_next.state = hss_pkg::S_WAIT;
          unique case (q_reg.step)
            3'h1: q_next.drv_stop_dec = 1'b1;
            3'h2: begin
              // Limit detection stops as the axis word says
              q_next.drv_stop_dec = step_lim[2] & q_reg.axis_mode[hss_pkg::AX_LIMIT_DEC];
              q_next.drv_stop_now = ~(step_lim[2] & q_reg.axis_mode[hss_pkg::AX_LIMIT_DEC]);
              q_next.lp_clr       = q_reg.mode1[hss_pkg::M1_S2_LP_CLR];
              q_next.rp_clr       = q_reg.mode1[hss_pkg::M1_S2_RP_CLR];
              q_next.clr_fire     = q_reg.mode1[hss_pkg::M1_S2_CLR_PULSE];
            end
            default: begin
              q_next.drv_stop_now = 1'b1;
              q_next.lp_clr       = q_reg.mode1[hss_pkg::M1_S3_LP_CLR];
              q_next.rp_clr       = q_reg.mode1[hss_pkg::M1_S3_RP_CLR];
              q_next.clr_fire     = q_reg.mode1[hss_pkg::M1_S3_CLR_PULSE] & idx_fall;
            end
          endcase
        end
      end
      hss_pkg::S_WAIT: begin
        if (!DRIVE_BUSY) begin
          if (q_reg.err_limit) begin
            q_next.state = hss_pkg::S_IDLE;
          end else if (q_reg.escaping) begin
            // Leave the step two detection region (home or limit), then search the programmed way
            q_next.escaping      = 1'b0;
            q_next.drv_dir_minus = step_dir[2];
            q_next.drv_start     = 1'b1;
            q_next.busy_seen     = 1'b0;
            q_next.state         = hss_pkg::S_RUN;
          end else if (q_reg.mode2[hss_pkg::M2_TIMER_EN]) begin
            q_next.timer = 32'h0000_0000;
            q_next.state = hss_pkg::S_DWELL;
          end else begin
            q_next.state = hss_pkg::S_NEXT;
          end
        end
      end
      hss_pkg::S_DWELL: begin
        q_next.timer = q_reg.timer + 32'h0000_0001;
        if (q_reg.timer >= timer_len - 32'h0000_0001) begin
          q_next.state = hss_pkg::S_NEXT;
        end
      end
      hss_pkg::S_DONE: begin
        q_next.lp_clr = q_reg.mode2[hss_pkg::M2_END_LP_CLR];
        q_next.rp_clr = q_reg.mode2[hss_pkg::M2_END_RP_CLR];
        q_next.state  = hss_pkg::S_IDLE;
      end
      default: q_next.state = hss_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      q_reg           <= '0;
      q_reg.state     <= hss_pkg::S_IDLE;
      q_reg.axis_mode <= hss_pkg::REG_RESET;
      q_reg.mode1     <= hss_pkg::REG_RESET;
      q_reg.mode2     <= hss_pkg::REG_RESET;
      q_reg.filt_mode <= hss_pkg::REG_RESET;
      q_reg.speed_hi  <= hss_pkg::WORD_RESET;
      q_reg.speed_lo  <= hss_pkg::WORD_RESET;
      q_reg.offset    <= hss_pkg::WORD_RESET;
      q_reg.idx_prev  <= hss_pkg::FILTER_IDLE;
    end else begin
      q_reg <= q_next;
    end
  end

  // ****************************************
  // Clear pulse and outputs
  // ****************************************
  hss_clear_pulse #(
    .UNIT_CYC (PULSE_UNIT_CYC)
  ) u_clear_pulse (
    .clk        (REF_CLK),
    .arst_n     (ARST_N),
    .fire       (q_reg.clr_fire),
    .width_code (q_reg.mode2[hss_pkg::M2_WIDTH_HI:hss_pkg::M2_WIDTH_LO]),
    .active_low (q_reg.mode2[hss_pkg::M2_PULSE_POL]),
    .pulse_out  (DEVIATION_CLEAR_OUTPUT)
  );

  assign HRDATA                       = q_reg.rdata;
  assign HREADYOUT                    = 1'b1;
  assign HRESP                        = 1'b0;
  assign DRIVE_START                  = q_reg.drv_start;
  assign DRIVE_FIXED                  = q_reg.drv_fixed;
  assign DRIVE_DIR_MINUS              = q_reg.drv_dir_minus;
  assign DRIVE_SPEED                  = q_reg.drv_speed;
  assign DRIVE_COUNT                  = q_reg.drv_count;
  assign DRIVE_STOP_DEC               = q_reg.drv_stop_dec;
  assign DRIVE_STOP_NOW               = q_reg.drv_stop_now;
  assign LOGICAL_POSITION_COUNTER_CLR = q_reg.lp_clr;
  assign REAL_POSITION_COUNTER_CLR    = q_reg.rp_clr;
  assign SEARCH_BUSY                  = q_reg.state != hss_pkg::S_IDLE;

endmodule

// [logic/hss_pkg.sv]
// Constants, register map and command codes of the home search sequencer
package hss_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_COMMAND  = 8'h00;
  localparam logic [7:0] ADDR_AXIS     = 8'h04;
  localparam logic [7:0] ADDR_DATA_LO  = 8'h08;
  localparam logic [7:0] ADDR_DATA_HI  = 8'h0C;
  localparam logic [7:0] ADDR_STATUS   = 8'h10;
  localparam logic [7:0] ADDR_MODE1    = 8'h14;
  localparam logic [7:0] ADDR_MODE2    = 8'h18;
  localparam logic [15:0] REG_RESET    = 16'h0000;
  localparam logic [31:0] WORD_RESET   = 32'h0000_0000;

  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [15:0] CMD_SPEED_HIGH = 16'h0105;
  localparam logic [15:0] CMD_OFFSET     = 16'h0106;
  localparam logic [15:0] CMD_SPEED_LOW  = 16'h0114;
  localparam logic [15:0] CMD_MODE1      = 16'h0123;
  localparam logic [15:0] CMD_MODE2      = 16'h0124;
  localparam logic [15:0] CMD_FILTER     = 16'h0125;
  localparam logic [15:0] CMD_START      = 16'h015A;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int AX_LIMIT_HIGH   = 10;
  localparam int AX_LIMIT_EN     = 11;
  localparam int AX_LIMIT_DEC    = 12;
  localparam int M1_S1_EN        = 0;
  localparam int M1_S1_DIR       = 1;
  localparam int M1_S1_SEL_LO    = 2;
  localparam int M1_S1_SEL_HI    = 3;
  localparam int M1_S2_EN        = 4;
  localparam int M1_S2_DIR       = 5;
  localparam int M1_S2_SEL       = 6;
  localparam int M1_S2_CLR_PULSE = 7;
  localparam int M1_S2_RP_CLR    = 8;
  localparam int M1_S2_LP_CLR    = 9;
  localparam int M1_S3_EN        = 10;
  localparam int M1_S3_DIR       = 11;
  localparam int M1_S3_CLR_PULSE = 12;
  localparam int M1_S3_RP_CLR    = 13;
  localparam int M1_S3_LP_CLR    = 14;
  localparam int M1_S4_EN        = 15;
  localparam int M2_END_RP_CLR   = 1;
  localparam int M2_END_LP_CLR   = 2;
  localparam int M2_PULSE_POL    = 3;
  localparam int M2_WIDTH_LO     = 4;
  localparam int M2_WIDTH_HI     = 6;
  localparam int M2_TIMER_EN     = 7;
  localparam int M2_TIMER_LO     = 8;
  localparam int M2_TIMER_HI     = 10;
  localparam int FM_CODE_LO      = 8;
  localparam int FM_CODE_HI      = 11;
  localparam logic [1:0] SEL_LIMIT = 2'h2;
  localparam logic [1:0] SEL_INDEX = 2'h1;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_MHZ         = 200;
  localparam int unsigned FILTER_UNIT_NS  = 500;
  localparam int unsigned FILTER_UNIT_CYC = FILTER_UNIT_NS * CLK_MHZ / 1000;
  localparam int unsigned PULSE_UNIT_US   = 10;
  localparam int unsigned PULSE_UNIT_CYC  = PULSE_UNIT_US * CLK_MHZ;
  localparam int unsigned TIMER_UNIT_US   = 1000;
  localparam int unsigned TIMER_UNIT_CYC  = TIMER_UNIT_US * CLK_MHZ;
  localparam logic FILTER_IDLE = 1'b1;

  // Input order of the filter bank
  localparam int IN_HOME  = 0;
  localparam int IN_INDEX = 1;
  localparam int IN_LIM_M = 2;
  localparam int IN_LIM_P = 3;
  localparam int IN_COUNT = 4;

  typedef enum logic [5:0] {
    S_IDLE  = 6'h01,
    S_NEXT  = 6'h02,
    S_RUN   = 6'h04,
    S_WAIT  = 6'h08,
    S_DWELL = 6'h10,
    S_DONE  = 6'h20
  } hss_state_t;

  // Multiplier table for the clear-pulse width and inter-step timer codes
  function automatic logic [31:0] hss_units(input logic [2:0] code);
    unique case (code)
      3'h0: hss_units = 32'h0000_0001;
      3'h1: hss_units = 32'h0000_0002;
      3'h2: hss_units = 32'h0000_000A;
      3'h3: hss_units = 32'h0000_0014;
      3'h4: hss_units = 32'h0000_0064;
      3'h5: hss_units = 32'h0000_00C8;
      3'h6: hss_units = 32'h0000_03E8;
      3'h7: hss_units = 32'h0000_07D0;
    endcase
  endfunction

endpackage

// [logic/hss_input_filter.sv]
// Digital noise filter for one sensor input
`timescale 1ns/10ps
module hss_input_filter #(
  parameter int unsigned UNIT_CYC = hss_pkg::FILTER_UNIT_CYC
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       raw,
  input  wire logic       enable,
  input  wire logic [3:0] code,
  output logic            filtered
);

  typedef struct packed {
    logic [31:0] cnt;
    logic        level;
  } hss_filt_t;

  hss_filt_t   q_reg;
  hss_filt_t   q_next;
  logic [31:0] limit;

  // Delay doubles per code step; code 10 gives 512 us at the default unit
  assign limit = 32'(UNIT_CYC << code);

  always_comb begin
    q_next = q_reg;
    if (!enable) begin
      q_next.level = raw;
      q_next.cnt   = 32'h0000_0000;
    end else if (raw == q_reg.level) begin
      q_next.cnt = 32'h0000_0000;
    end else if (q_reg.cnt >= limit - 32'h0000_0001) begin
      q_next.level = raw;
      q_next.cnt   = 32'h0000_0000;
    end else begin
      q_next.cnt = q_reg.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q_reg <= '{cnt: 32'h0000_0000, level: hss_pkg::FILTER_IDLE};
    end else begin
      q_reg <= q_next;
    end
  end

  assign filtered = q_reg.level;

endmodule

// [logic/hss_clear_pulse.sv]
// Deviation-counter clear pulse generator with programmable width and polarity
`timescale 1ns/10ps
module hss_clear_pulse #(
  parameter int unsigned UNIT_CYC = hss_pkg::PULSE_UNIT_CYC
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       fire,
  input  wire logic [2:0] width_code,
  input  wire logic       active_low,
  output logic            pulse_out
);

  typedef struct packed {
    logic        active;
    logic [31:0] cnt;
    logic        out;
  } hss_pulse_t;

  hss_pulse_t  q_reg;
  hss_pulse_t  q_next;
  logic [31:0] length;

  assign length = 32'(UNIT_CYC * hss_pkg::hss_units(width_code));

  always_comb begin
    q_next = q_reg;
    if (fire) begin
      q_next.active = 1'b1;
      q_next.cnt    = 32'h0000_0000;
    end else if (q_reg.active) begin
      if (q_reg.cnt >= length - 32'h0000_0001) begin
        q_next.active = 1'b0;
      end else begin
        q_next.cnt = q_reg.cnt + 32'h0000_0001;
      end
    end
    q_next.out = q_next.active ^ active_low;
  end

  // Idle level follows polarity one cycle after it changes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q_reg <= '{active: 1'b0, cnt: 32'h0000_0000, out: 1'b0};
    end else begin
      q_reg <= q_next;
    end
  end

  assign pulse_out = q_reg.out;

endmodule

// [tb/hss_sva.sv]
// Port assertions for the home search sequencer
`timescale 1ns/10ps
module hss_sva (
  input wire logic        REF_CLK,
  input wire logic        ARST_N,
  input wire logic        DRIVE_BUSY,
  input wire logic        DRIVE_START,
  input wire logic        DRIVE_DIR_MINUS,
  input wire logic [31:0] DRIVE_SPEED,
  input wire logic        DRIVE_STOP_NOW,
  input wire logic        DEVIATION_CLEAR_OUTPUT,
  input wire logic        LOGICAL_POSITION_COUNTER_CLR,
  input wire logic        REAL_POSITION_COUNTER_CLR,
  input wire logic        SEARCH_BUSY
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  chk_start_single: assert property (DRIVE_START |=> !DRIVE_START)
    else $error("start too long");
  chk_start_busy: assert property (DRIVE_START |-> SEARCH_BUSY)
    else $error("start while idle");
  chk_halt_busy: assert property (DRIVE_STOP_NOW |-> SEARCH_BUSY)
    else $error("halt while idle");
  chk_lp_single: assert property ($rose(LOGICAL_POSITION_COUNTER_CLR) |=> !LOGICAL_POSITION_COUNTER_CLR)
    else $error("logical clear too long");
  chk_rp_single: assert property ($rose(REAL_POSITION_COUNTER_CLR) |=> !REAL_POSITION_COUNTER_CLR)
    else $error("real clear too long");
  chk_dir_stands: assert property (DRIVE_BUSY && !DRIVE_START |-> $stable(DRIVE_DIR_MINUS))
    else $error("direction moved");
  chk_speed_stands: assert property (DRIVE_BUSY && !DRIVE_START |-> $stable(DRIVE_SPEED))
    else $error("speed moved");
  chk_pulse_width: assert property ($rose(DEVIATION_CLEAR_OUTPUT) |-> DEVIATION_CLEAR_OUTPUT[*8])
    else $error("clear pulse short");
  cover property (DRIVE_START);
  cover property ($rose(DEVIATION_CLEAR_OUTPUT));
  cover property ($fell(SEARCH_BUSY));
endmodule
bind hss_home_search hss_sva i_hss_sva (.*);

// [tb/hss_drive_model.sv]
// Pulse engine model on the drive link
`timescale 1ns/10ps
module hss_drive_model (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic start,
  input  wire logic fixed,
  input  wire logic stop_dec,
  input  wire logic stop_now,
  output logic      busy
);
  int cnt;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy <= 1'b0;
      cnt <= 0;
    end else if (start) begin
      busy <= 1'b1;
      cnt <= fixed ? 20 : 0;
    end else if (stop_now || stop_dec) begin
      cnt <= stop_now ? 1 : 4;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (cnt == 1) begin
      busy <= 1'b0;
      cnt <= 0;
    end
  end
endmodule

// [tb/hss_home_search_bench.sv]
// Self-checking bench for the home search sequencer
`timescale 1ns/10ps
module hss_home_search_bench;
  logic clk, rst_n, t1, hw, home, idx, mlim, st, fx, dir, dec, now, dco, lpc, rpc, sb, busy, hro, hrs;
  logic [31:0] ha, hwd, hrd, spd, cnt, rd;
  logic [32:0] q[$], e;
  logic [15:0] hs;
  int bad_count, n_tests, seed, lp_n, rp_n, w;
  hss_home_search #(.PULSE_UNIT_CYC(2)) i_hss_home_search (.REF_CLK(clk), .ARST_N(rst_n),
    .HSEL(1'b1), .HADDR(ha), .HTRANS({t1, 1'b0}), .HWRITE(hw), .HSIZE(3'h2), .HWDATA(hwd),
    .HREADY(hro), .HRDATA(hrd), .HREADYOUT(hro), .HRESP(hrs), .HOME_SENSOR_INPUT_N(home),
    .ENCODER_INDEX_INPUT_N(idx), .MINUS_LIMIT_INPUT(mlim), .PLUS_LIMIT_INPUT(1'b1),
    .DRIVE_BUSY(busy), .DRIVE_START(st), .DRIVE_FIXED(fx), .DRIVE_DIR_MINUS(dir),
    .DRIVE_SPEED(spd), .DRIVE_COUNT(cnt), .DRIVE_STOP_DEC(dec), .DRIVE_STOP_NOW(now),
    .DEVIATION_CLEAR_OUTPUT(dco), .LOGICAL_POSITION_COUNTER_CLR(lpc),
    .REAL_POSITION_COUNTER_CLR(rpc), .SEARCH_BUSY(sb));
  hss_drive_model i_hss_drive_model (.clk(clk), .arst_n(rst_n), .start(st), .fixed(fx),
    .stop_dec(dec), .stop_now(now), .busy(busy));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Bounded wait: 0 start, 1 search over, 2 clear pulse, 3 bus ready
  task automatic waitfor(input int k);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (!(k == 0 ? st : k == 1 ? !sb : k == 2 ? dco : hro) && n < 30000);
    if (n >= 30000) begin
      bad_count++;
      give_verdict();
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
    t1 <= 1'b1;
    ha <= {24'h0, a};
    hw <= wr;
    waitfor(3);
    t1 <= 1'b0;
    hwd <= d;
    waitfor(3);
    rd = hrd;
  endtask
  // Data word first, the command acts on it
  task automatic cmd(input logic [15:0] d, input logic [15:0] c);
    bus(hss_pkg::ADDR_DATA_LO, 1, {16'h0, d});
    bus(hss_pkg::ADDR_COMMAND, 1, {16'h0, c});
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Starts sampled mid-cycle, away from the launching edge
  always @(negedge clk) begin
    if (st === 1'b1) begin
      e = q.size() ? q.pop_front() : 33'h0;
      check({dir, spd[30:0]}, {e[32], e[30:0]});
    end
    lp_n += (lpc === 1'b1);
    rp_n += (rpc === 1'b1);
  end
  initial begin
    {rst_n, t1, hw, ha, hwd, lp_n, rp_n, bad_count, n_tests} = '0;
    {home, idx, mlim, seed} = {3'b111, 32'h5};
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    hs = 16'h4E20 ^ 16'($random(seed) & 32'h0FFF);
    bus(hss_pkg::ADDR_AXIS, 1, 32'h0);
    cmd(16'hFC33, hss_pkg::CMD_MODE1);
    cmd(16'h0020, hss_pkg::CMD_MODE2);
    cmd(hs, hss_pkg::CMD_SPEED_HIGH);
    cmd(16'h01F4, hss_pkg::CMD_SPEED_LOW);
    cmd(16'h0DAC, hss_pkg::CMD_OFFSET);
    bus(hss_pkg::ADDR_MODE1, 1, 32'h0);
    bus(hss_pkg::ADDR_MODE1, 0, 32'h0);
    check(rd, 32'hFC33);
    bus(hss_pkg::ADDR_MODE2, 0, 32'h0);
    check(rd, 32'h0020);
    bus(8'h1C, 0, 32'h0);
    check(rd, 32'h0);
    check(hrs, 1'b0);
    q = '{{17'h10000, hs}, 33'h1F4, 33'h1000001F4, 33'h1000001F4, {17'h0, hs}};
    bus(hss_pkg::ADDR_COMMAND, 1, {16'h0, hss_pkg::CMD_START});
    waitfor(0);
    home <= 1'b0;
    waitfor(0);
    home <= 1'b1;
    waitfor(0);
    home <= 1'b0;
    waitfor(0);
    idx <= 1'b0;
    waitfor(2);
    w = 1;
    while (dco === 1'b1 && w < 999) begin
      @(posedge clk);
      #1 w++;
    end
    check(w - 1, 32'd20);
    idx <= 1'b1;
    waitfor(1);
    check(cnt, 32'd3500);
    check(fx, 1'b1);
    check(lp_n + rp_n * 2, 3);
    check(q.size(), 0);
    bus(hss_pkg::ADDR_STATUS, 0, 32'h0);
    check(rd & 32'h3F1, 32'h380);
    // Second search homes on the minus limit through its filter
    cmd(16'h0004, hss_pkg::CMD_FILTER);
    mlim <= 1'b0;
    bus(hss_pkg::ADDR_AXIS, 1, 32'h1800);
    cmd(16'h807B, hss_pkg::CMD_MODE1);
    repeat (120) @(posedge clk);
    q = '{33'h1F4, 33'h1000001F4, {17'h0, hs}};
    bus(hss_pkg::ADDR_COMMAND, 1, {16'h0, hss_pkg::CMD_START});
    waitfor(0);
    mlim <= 1'b1;
    waitfor(0);
    mlim <= 1'b0;
    waitfor(1);
    check(q.size(), 0);
    give_verdict();
  end
endmodule
